/* core/arw_top.sv */
// adc result path: accumulate, justify, result bytes, window flag, apb registers
// assumes a sar core that converts once per sarStart and returns one sample pulse,
// and an apb master on ref_clk
`timescale 1ns/100ps
module arw_top
    import arw_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        convTrigger,
    input  wire arw_sample_t sample,
    output logic             sarStart,
    output logic             powerReq,
    output logic             busy,
    output logic             windowFlag,
    output logic             sarClk
);

    // register state
    logic        alwaysOnEnable;
    logic        burstModeEnable;
    logic [6:0]  accCfg;
    logic [7:0]  resultHighByte;
    logic [7:0]  resultLowByte;
    arw_limits_t limits;
    logic [4:0]  sarClockDivider;
    logic        swStart;

    logic        next_alwaysOnEnable;
    logic        next_burstModeEnable;
    logic [6:0]  next_accCfg;
    logic        next_windowFlag;
    arw_limits_t next_limits;
    logic [4:0]  next_sarClockDivider;
    logic        next_swStart;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // conversion state
    arw_state_t  state;
    arw_state_t  next_state;
    logic [15:0] acc;
    logic [15:0] next_acc;
    logic [6:0]  remaining;
    logic [6:0]  next_remaining;
    logic [3:0]  timer;
    logic [3:0]  next_timer;
    logic [7:0]  next_resultHighByte;
    logic [7:0]  next_resultLowByte;
    logic        next_sarStart;
    logic        next_powerReq;
    logic        next_busy;

    // sar clock divider state
    logic [4:0]  sarCount;
    logic [4:0]  next_sarCount;
    logic        next_sarClk;

    logic        loadResult;
    logic [15:0] formatted;
    logic        windowHit;
    logic [2:0]  justSel;
    logic [2:0]  rptSel;
    logic        twelveBit;

    assign justSel   = accCfg[ACC_JUST_LSB +: 3];
    assign rptSel    = accCfg[ACC_RPT_LSB +: 3];
    assign twelveBit = accCfg[ACC_TWELVE_BIT];

    // conversions per trigger; non-burst mode always takes one
    function automatic logic [6:0] conv_count(input logic [2:0] sel, input logic twelve,
                                              input logic burst);
        logic [6:0] n;
        n = 7'h01;
        unique case (sel)
            RPT_4:   n = 7'h04;
            RPT_8:   n = 7'h08;
            RPT_16:  n = 7'h10;
            RPT_32:  n = 7'h20;
            RPT_64:  n = 7'h40;
            default: n = 7'h01;
        endcase
        if (twelve && n < TWELVE_MIN_COUNT) begin
            n = TWELVE_MIN_COUNT; // RQ17
        end
        if (!burst) begin
            n = 7'h01;
        end
        return n;
    endfunction

    // justify or shift the sum; shifting zero-fills unused bits
    function automatic logic [15:0] format_sum(input logic [15:0] sum, input logic [2:0] sel);
        logic [15:0] r;
        r = sum;
        unique case (sel)
            JUST_RIGHT: r = sum;                              // RQ2
            JUST_SHR1:  r = sum >> 1;                         // RQ8
            JUST_SHR2:  r = sum >> 2;                         // RQ8
            JUST_SHR3:  r = sum >> 3;                         // RQ8
            JUST_LEFT:  r = {sum[9:0], {LEFT_PAD{1'b0}}};     // RQ2 RQ3 RQ4
            default:    r = sum;
        endcase
        return r;
    endfunction

    // sum including the sample arriving now, so the last one is not lost
    assign formatted = format_sum(acc + {6'h00, sample.code}, justSel);

    arw_window u_window (
        .result (formatted),
        .limits (limits),
        .hit    (windowHit)
    );

    // conversion sequencer: trigger, power-up once, start/wait per sample
    always_comb begin
        next_state          = state;
        next_acc            = acc;
        next_remaining      = remaining;
        next_timer          = timer;
        next_resultHighByte = resultHighByte;
        next_resultLowByte  = resultLowByte;
        loadResult          = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (convTrigger || swStart) begin
                    next_acc       = 16'h0000; // RQ20
                    next_remaining = conv_count(rptSel, twelveBit, burstModeEnable); // RQ6
                    if (alwaysOnEnable) begin
                        next_state = ST_START;
                    end else begin
                        next_timer = 4'(POWERUP_CYCLES - 1);
                        next_state = ST_POWER; // RQ15
                    end
                end
            end
            ST_POWER: begin
                if (timer == 4'h0) begin
                    next_state = ST_START;
                end else begin
                    next_timer = timer - 4'h1;
                end
            end
            ST_START: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (sample.valid) begin
                    next_acc = acc + {6'h00, sample.code}; // RQ9 RQ17
                    if (remaining == 7'h01) begin
                        // only the final sample of the series updates the bytes
                        loadResult          = 1'b1; // RQ5
                        next_resultHighByte = formatted[15:8]; // RQ1
                        next_resultLowByte  = formatted[7:0];  // RQ1
                        next_state          = ST_IDLE;
                    end else begin
                        next_remaining = remaining - 7'h01;
                        next_state     = ST_START; // RQ15
                    end
                end
            end
        endcase
        // triggers outside idle are simply not looked at
        next_busy     = (next_state != ST_IDLE); // RQ18
        next_sarStart = (next_state == ST_START);
        next_powerReq = alwaysOnEnable || (next_state != ST_IDLE);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state          <= ST_IDLE;
            acc            <= 16'h0000;
            remaining      <= 7'h00;
            timer          <= 4'h0;
            resultHighByte <= 8'h00;
            resultLowByte  <= 8'h00;
            sarStart       <= 1'b0;
            powerReq       <= 1'b0;
            busy           <= 1'b0;
        end else begin
            state          <= next_state;
            acc            <= next_acc;
            remaining      <= next_remaining;
            timer          <= next_timer;
            resultHighByte <= next_resultHighByte;
            resultLowByte  <= next_resultLowByte;
            sarStart       <= next_sarStart;
            powerReq       <= next_powerReq;
            busy           <= next_busy;
        end
    end

    // apb slave: read data latched in first access cycle, pready and write commit in second
    logic        accessFirst;
    logic        writeCommit;
    logic        mapped;
    logic [31:0] readData;

    assign accessFirst = psel && penable && !pready;
    assign writeCommit = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        mapped   = 1'b1;
        readData = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: begin
                readData[CTRL_ALWAYS_ON_BIT] = alwaysOnEnable;
                readData[CTRL_BURST_BIT]     = burstModeEnable;
                readData[CTRL_WINDOW_BIT]    = windowFlag; // RQ14
                readData[CTRL_BUSY_BIT]      = busy;
            end
            OFS_ACCCFG: readData[6:0]  = accCfg;
            OFS_RES_HI: readData[7:0]  = resultHighByte;
            OFS_RES_LO: readData[7:0]  = resultLowByte;
            OFS_GT_HI:  readData[7:0]  = limits.greater[15:8]; // RQ11
            OFS_GT_LO:  readData[7:0]  = limits.greater[7:0];
            OFS_LT_HI:  readData[7:0]  = limits.less[15:8];
            OFS_LT_LO:  readData[7:0]  = limits.less[7:0];
            OFS_SARDIV: readData[4:0]  = sarClockDivider; // RQ16
            default:    mapped = 1'b0;
        endcase
    end

    // register writes and window flag; a hit in the clearing cycle wins
    always_comb begin
        next_alwaysOnEnable  = alwaysOnEnable;
        next_burstModeEnable = burstModeEnable;
        next_accCfg          = accCfg;
        next_limits          = limits;
        next_sarClockDivider = sarClockDivider;
        next_windowFlag      = windowFlag;
        next_swStart         = 1'b0;
        if (writeCommit) begin
            unique case (paddr)
                OFS_CTRL: begin
                    next_alwaysOnEnable  = pwdata[CTRL_ALWAYS_ON_BIT];
                    next_burstModeEnable = pwdata[CTRL_BURST_BIT];
                    // writing zero clears, writing one leaves it
                    if (!pwdata[CTRL_WINDOW_BIT]) begin
                        next_windowFlag = 1'b0; // RQ19
                    end
                    next_swStart = pwdata[CTRL_START_BIT];
                end
                OFS_ACCCFG: next_accCfg                = pwdata[6:0];
                OFS_GT_HI:  next_limits.greater[15:8]  = pwdata[7:0]; // RQ11
                OFS_GT_LO:  next_limits.greater[7:0]   = pwdata[7:0];
                OFS_LT_HI:  next_limits.less[15:8]     = pwdata[7:0];
                OFS_LT_LO:  next_limits.less[7:0]      = pwdata[7:0];
                OFS_SARDIV: next_sarClockDivider       = pwdata[4:0];
                default:    next_swStart               = 1'b0;
            endcase
        end
        if (loadResult && windowHit) begin
            next_windowFlag = 1'b1; // RQ10 RQ19
        end
        next_pready  = accessFirst;
        next_prdata  = accessFirst ? readData : prdata;
        next_pslverr = accessFirst ? !mapped : 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alwaysOnEnable  <= 1'b0;
            burstModeEnable <= 1'b0;
            accCfg          <= ACCCFG_RESET;
            limits.greater  <= GT_RESET;
            limits.less     <= LT_RESET;
            sarClockDivider <= SARDIV_RESET;
            windowFlag      <= 1'b0;
            swStart         <= 1'b0;
            prdata          <= 32'h0000_0000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
        end else begin
            alwaysOnEnable  <= next_alwaysOnEnable;
            burstModeEnable <= next_burstModeEnable;
            accCfg          <= next_accCfg;
            limits          <= next_limits;
            sarClockDivider <= next_sarClockDivider;
            windowFlag      <= next_windowFlag;
            swStart         <= next_swStart;
            prdata          <= next_prdata;
            pready          <= next_pready;
            pslverr         <= next_pslverr;
        end
    end

    // sar clock: toggles every divider+1 ref clocks
    always_comb begin
        next_sarCount = sarCount + 5'h01;
        next_sarClk   = sarClk;
        if (sarCount >= sarClockDivider) begin
            next_sarCount = 5'h00;
            next_sarClk   = !sarClk;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sarCount <= 5'h00;
            sarClk   <= 1'b0;
        end else begin
            sarCount <= next_sarCount;
            sarClk   <= next_sarClk;
        end
    end

endmodule

/* core/arw_window.sv */
// window comparator of the result path
// assumes result and limits are stable in the cycle they are looked at
`timescale 1ns/100ps
module arw_window
    import arw_pkg::*;
(
    input  wire logic [15:0] result,
    input  wire arw_limits_t limits,
    output logic             hit
);

    // inside window when less limit lies above greater limit, else outside
    always_comb begin
        if (limits.less > limits.greater) begin
            hit = (result > limits.greater) && (result < limits.less); // RQ12
        end else begin
            hit = (result < limits.less) || (result > limits.greater); // RQ13
        end
    end

endmodule

/* inc/arw_pkg.sv */
// constants, field layout and carrier types of the adc result/accumulate/window block
// assumes an apb master in the ref_clk domain and a sar core that returns one code per start
// Behaviour
// RQ1 - each finished conversion or series loads a high and a low result byte
// RQ2 - justify/shift code 000 right-justifies, 100 left-justifies the result
// RQ3 - single 10-bit result is unsigned; full scale 0x03FF right, 0xFFC0 left
// RQ4 - bits unused by justification and resolution read as zero
// RQ5 - repeat above one presents the sum, updated only after the last conversion
// RQ6 - series of 4, 8, 16, 32 or 64 samples accumulate unsigned, set by repeat field
// RQ7 - software keeps right justification whenever repeat count exceeds one
// RQ8 - sum held in 16 bits, optionally shifted right by one, two or three
// RQ9 - accumulator is a plain sum: 2^n equal samples give code shifted left n
// RQ10 - window detector compares result against two programmed limits without software
// RQ11 - greater and less limits are 16 bits each, split in high and low bytes
// RQ12 - less limit above greater limit: flag when strictly between them
// RQ13 - otherwise flag when result strictly below lower or strictly above upper bound
// RQ14 - window flag sits in control register, usable polled or as interrupt
// RQ15 - power-up interval spent once per burst, not per conversion
// RQ16 - software sets sar divider assuming 24.5 MHz system clock, adjusting otherwise
// RQ17 - twelve-bit mode sums four 10-bit conversions, maximum 4092; code sums the larger of four and the repeat count, one with burst off
// RQ18 - start triggers arriving before the burst completes are ignored
// RQ19 - window flag sticky until software clears it; evaluated on each result update
// RQ20 - accumulator cleared at start of every new series
package arw_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_ACCCFG  = 8'h04;
    localparam logic [7:0] OFS_RES_HI  = 8'h08;
    localparam logic [7:0] OFS_RES_LO  = 8'h0C;
    localparam logic [7:0] OFS_GT_HI   = 8'h10;
    localparam logic [7:0] OFS_GT_LO   = 8'h14;
    localparam logic [7:0] OFS_LT_HI   = 8'h18;
    localparam logic [7:0] OFS_LT_LO   = 8'h1C;
    localparam logic [7:0] OFS_SARDIV  = 8'h20;

    // control register fields
    localparam int CTRL_ALWAYS_ON_BIT = 0;
    localparam int CTRL_BURST_BIT     = 1;
    localparam int CTRL_WINDOW_BIT    = 2;
    localparam int CTRL_BUSY_BIT      = 3;
    localparam int CTRL_START_BIT     = 4;

    // accumulator config fields
    localparam int ACC_JUST_LSB   = 0;
    localparam int ACC_RPT_LSB    = 3;
    localparam int ACC_TWELVE_BIT = 6;

    // reset values
    localparam logic [6:0]  ACCCFG_RESET = 7'h00;
    localparam logic [15:0] GT_RESET     = 16'hFFFF;
    localparam logic [15:0] LT_RESET     = 16'h0000;
    localparam logic [4:0]  SARDIV_RESET = 5'h1F;

    // justify/shift codes
    localparam logic [2:0] JUST_RIGHT  = 3'h0;
    localparam logic [2:0] JUST_SHR1   = 3'h1;
    localparam logic [2:0] JUST_SHR2   = 3'h2;
    localparam logic [2:0] JUST_SHR3   = 3'h3;
    localparam logic [2:0] JUST_LEFT   = 3'h4;
    localparam int         LEFT_PAD    = 6;

    // repeat count codes
    localparam logic [2:0] RPT_1  = 3'h0;
    localparam logic [2:0] RPT_4  = 3'h1;
    localparam logic [2:0] RPT_8  = 3'h2;
    localparam logic [2:0] RPT_16 = 3'h3;
    localparam logic [2:0] RPT_32 = 3'h4;
    localparam logic [2:0] RPT_64 = 3'h5;
    localparam logic [6:0] TWELVE_MIN_COUNT = 7'h04;

    // power-up interval before the first conversion of a burst
    localparam int CLK_PERIOD_NS  = 100;
    localparam int POWERUP_NS     = 1000;
    localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_POWER = 2'b01,
        ST_START = 2'b10,
        ST_WAIT  = 2'b11
    } arw_state_t;

    // one code returned by the sar core
    typedef struct packed {
        logic       valid;
        logic [9:0] code;
    } arw_sample_t;

    // window limits
    typedef struct packed {
        logic [15:0] greater;
        logic [15:0] less;
    } arw_limits_t;

endpackage

/* sim/arw_top_monitor.sv */
// port-level checks of the result path: apb answer, series timing, window flag
// assumes arw_top with one clock and an async active-low reset
`timescale 1ns/100ps
module arw_monitor
    import arw_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        convTrigger,
    input wire arw_sample_t sample,
    input wire logic        sarStart,
    input wire logic        powerReq,
    input wire logic        busy,
    input wire logic        windowFlag,
    input wire logic        sarClk
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // bus answers one cycle after the first access edge
    chk_ready_after_access: assert property ($rose(penable) && psel |=> pready)
        else $error("apb answer late");
    chk_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // one conversion request per pulse, only inside a series
    chk_start_in_series: assert property (sarStart |-> busy ##1 !sarStart)
        else $error("stray conversion request");
    chk_power_while_busy: assert property (busy |-> powerReq)
        else $error("series without power");
    // power-up wait only at the head of a burst
    chk_powerup_once: assert property ($rose(powerReq) && busy |-> !sarStart [*8] ##[1:6] sarStart)
        else $error("power-up wait wrong");
    chk_idle_trigger: assert property (convTrigger && !busy && powerReq |=> busy && sarStart)
        else $error("idle trigger not taken");
    chk_result_after_last: assert property ($fell(busy) |-> $past(sample.valid))
        else $error("series ended without last sample");
    // flag only rises on a result update and only software clears it
    chk_flag_on_update: assert property ($rose(windowFlag) |-> $past(sample.valid))
        else $error("flag rose without update");
    chk_flag_sticky: assert property (windowFlag && !(psel && pwrite && paddr == OFS_CTRL)
        |=> windowFlag)
        else $error("flag dropped by itself");
endmodule

bind arw_top arw_monitor u_arw_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convTrigger(convTrigger), .sample(sample),
    .sarStart(sarStart), .powerReq(powerReq), .busy(busy), .windowFlag(windowFlag),
    .sarClk(sarClk));

/* sim/arw_top_tb_top.sv */
// self-checking bench of the result path: apb driver, sar responder, queued compares
// assumes arw_top with the package register map and one 10 MHz clock
`timescale 1ns/100ps
module arw_top_tb_top
    import arw_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, sarStart, powerReq, busy, windowFlag, sarClk;
    logic        convTrigger = 1'b0;
    arw_sample_t sample = '0;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          starts = 0;
    logic [32:0] expQ[$];
    logic [9:0]  codeQ[$];
    logic [31:0] rng = 32'h0000_0043;

    always #50 ref_clk = ~ref_clk;

    arw_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convTrigger(convTrigger), .sample(sample), .sarStart(sarStart),
        .powerReq(powerReq), .busy(busy), .windowFlag(windowFlag), .sarClk(sarClk));

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // sar stand-in: one code the cycle after each request, junk on the code lines otherwise
    always @(posedge ref_clk) begin
        sample.valid <= (sarStart === 1'b1);
        sample.code  <= (sarStart === 1'b1) ? codeQ.pop_front() : ~sample.code;
    end

    // answer watcher: oldest note against what the bus returned
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1)
            cmp(expQ.pop_front(), {pslverr, pwrite ? 32'h0000_0000 : prdata});
        if (sarStart === 1'b1)
            starts++;
    end

    // one apb transfer; idle edge after release so strobes never reassign in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        expQ.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) num_errors++; // a slave that never answers is a fault
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {1'b0, e});
    endtask

    task automatic rdres(input logic [15:0] e);
        rd(OFS_RES_HI, {24'h00_0000, e[15:8]});
        rd(OFS_RES_LO, {24'h00_0000, e[7:0]});
    endtask

    // one sar clock half period in ref_clk cycles, measured from a change to the next
    task automatic sarper(input int e);
        logic s;
        int   c;
        s = sarClk;
        c = 0;
        while (sarClk === s && c < 100) begin
            @(posedge ref_clk);
            c++;
        end
        s = sarClk;
        c = 0;
        while (sarClk === s && c < 100) begin
            @(posedge ref_clk);
            c++;
        end
        cmp(33'(e), 33'(c));
    endtask

    // one series by trigger, a second trigger while busy must be dropped
    task automatic run(input logic [6:0] cfg, input logic [1:0] ctl, input int n);
        int k;
        wr(OFS_ACCCFG, {25'h000_0000, cfg});
        wr(OFS_CTRL, {29'h0000_0000, 1'b1, ctl});
        starts = 0;
        convTrigger <= 1'b1;
        @(posedge ref_clk);
        convTrigger <= 1'b0;
        k = 0;
        while (busy !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            k++;
        end
        if (busy !== 1'b1) num_errors++; // series never began
        convTrigger <= 1'b1;
        @(posedge ref_clk);
        convTrigger <= 1'b0;
        while (busy !== 1'b0 && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
        if (busy !== 1'b0) num_errors++; // series never ended
        @(posedge ref_clk);
        cmp(33'(n), 33'(starts));
    endtask

    initial begin
        logic [9:0]  sc[4];
        logic [9:0]  wc[8];
        logic [7:0]  wf;
        logic [15:0] sum;
        logic [9:0]  v;
        int          n;
        int          j;
        sc = '{10'h3FF, 10'h200, 10'h100, 10'h000};
        wc = '{10'h040, 10'h041, 10'h07F, 10'h080, 10'h03F, 10'h040, 10'h080, 10'h081};
        wf = 8'b1001_0110;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        // reset values of the limit registers but the less low byte, and of the divider register
        rd(OFS_GT_HI, 32'h0000_00FF);
        rd(OFS_GT_LO, 32'h0000_00FF);
        rd(OFS_LT_HI, 32'h0000_0000);
        rd(OFS_SARDIV, 32'h0000_001F);
        // divided clock at reset divider, then at a small one, then two unmapped places
        sarper(int'(SARDIV_RESET) + 1);
        wr(OFS_SARDIV, 32'h0000_0003);
        sarper(4);
        apb(1'b0, 8'h24, 32'h0000_0000, 33'h1_0000_0000);
        apb(1'b1, 8'h28, 32'hFFFF_FFFF, 33'h1_0000_0000);
        // single codes through every justify/shift code, always on
        for (j = 0; j < 5; j++) begin
            for (int i = 0; i < 4; i++) begin
                codeQ.push_back(sc[i]);
                run({4'h0, 3'(j)}, 2'b11, 1);
                rdres((j == 4) ? {sc[i], 6'h00} : ({6'h00, sc[i]} >> j));
            end
        end
        // bursts of 4..64 with power-up, shifts 1..3, full scale at 64
        for (int r = 1; r <= 5; r++) begin
            n = 4 << (r - 1);
            j = (r == 5) ? 0 : r % 4;
            sum = 16'h0000;
            for (int i = 0; i < n; i++) begin
                v = (r == 5) ? 10'h3FF : 10'(xs());
                codeQ.push_back(v);
                sum = sum + 16'(v);
            end
            run({1'b0, 3'(r), 3'(j)}, 2'b10, n);
            rdres(sum >> j);
        end
        // twelve-bit mode forces four full-scale codes
        repeat (4) codeQ.push_back(10'h3FF);
        run(7'h40, 2'b11, 4);
        rdres(16'h0FFC);
        // burst off ignores the repeat field
        v = 10'(xs());
        codeQ.push_back(v);
        run({1'b0, RPT_4, JUST_RIGHT}, 2'b01, 1);
        rdres({6'h00, v});
        // software start bit instead of the trigger pin, burst off so one sample
        codeQ.push_back(10'h155);
        wr(OFS_CTRL, 32'h0000_0015);
        repeat (4) @(posedge ref_clk);
        rdres(16'h0155);
        // window: inside then outside arrangement, each code from a cleared flag
        for (int i = 0; i < 8; i++) begin
            if (i % 4 == 0) begin
                wr(OFS_GT_LO, (i == 0) ? 32'h0000_0040 : 32'h0000_0080);
                wr(OFS_LT_LO, (i == 0) ? 32'h0000_0080 : 32'h0000_0040);
                wr(OFS_GT_HI, 32'h0000_0000);
            end
            wr(OFS_CTRL, 32'h0000_0003);
            codeQ.push_back(wc[i]);
            run(7'h00, 2'b11, 1);
            rd(OFS_CTRL, {29'h0000_0000, wf[i], 2'b11});
        end
        // a miss after a hit keeps the flag
        codeQ.push_back(10'h080);
        run(7'h00, 2'b11, 1);
        rd(OFS_CTRL, 32'h0000_0007);
        report_and_stop();
    end

    // hang guard, far beyond the roughly 1200 cycles the sequence needs
    initial begin
        #4000000;
        num_errors++;
        report_and_stop();
    end
endmodule
